/* File: src/sfd_decode_status.v */
// sfd_decode_status.v: float/SIMD opcode decode, compare condition field,
// shared status and control register, 64-bit register file
// assumes one instruction per cycle from a single issue stream and that
// execution units report flags as one-cycle pulses on the core clock
//
// Operation
// - primary 4, class 0101 00xx or 0101 010x is vector float
// - primary 4, class 0101 0110 or 0101 10xx is scalar float
// - class 0101 0111 and 0101 11xx is unimplemented double space
// - double form: unimplemented if extension bit set, else unavailable
// - vector float: 0101 then seven-bit op; rD, rA, rB fields
// - scalar float uses same layout with its own op codes
// - source-a 00100 picks half conversion, 00000 integer conversion
// - thirty-two 64-bit registers; base forms touch low 32 bits
// - bits 0-31 are high element, bits 32-63 low element
// - elements are two 32-bit, four 16-bit, or one 64-bit
// - one issue stream; no SIMD form updates condition implicitly
// - compare field holds high, low, their OR and AND
// - status register is special register 512 via move to/from
// - status register resets to zero and is read/write
// - upper int overflow sets bit 1 and sticky summary bit 0
// - low int overflow sets bit 17 and sticky summary bit 16
// - bits 2-7 high float flags, 18-23 low/scalar float flags
// - bits 10-14 sticky float flags; bits 8-9 reserved
// - bit 15 is float operating mode control
// - one status register shared by float and integer SIMD
// - bits 25-29 float trap enables; bit 24 reserved
// - bits 30-31 select float rounding mode
// - extension bit clear: SIMD except bit-reverse increment unavailable
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_decode_status (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // issue pipeline
  input  wire        insn_valid_i,
  input  wire [31:0] insn_i,
  input  wire        extension_available_bit_i,
  // decode results
  output wire        dec_valid_o,
  output wire        dec_vec_o,
  output wire        dec_scl_o,
  output wire        dec_half_o,
  output wire        dec_cmp_o,
  output wire        dec_illegal_o,
  output wire        dec_unimpl_o,
  output wire        dec_unavail_o,
  output wire [6:0]  dec_op_o,
  output wire [4:0]  dec_rd_o,
  output wire [4:0]  dec_ra_o,
  output wire [4:0]  dec_rb_o,
  // compare result from execution
  input  wire        cmp_done_i,
  input  wire [2:0]  cmp_field_i,
  input  wire        cmp_hi_i,
  input  wire        cmp_lo_i,
  output wire        cr_we_o,
  output wire [2:0]  compare_target_field_o,
  output wire [3:0]  cr_data_o,
  // special register access
  input  wire        spr_wr_i,
  input  wire        spr_rd_i,
  input  wire [9:0]  spr_num_i,
  input  wire [31:0] spr_wdata_i,
  output wire [31:0] spr_rdata_o,
  output wire        spr_hit_o,
  // status events from execution
  input  wire        int_upd_i,
  input  wire        high_int_wrap_i,
  input  wire        low_int_wrap_i,
  input  wire        flt_upd_i,
  input  wire [5:0]  flt_hi_i,
  input  wire [5:0]  flt_lo_i,
  // control fields to the float unit
  output wire [1:0]  rounding_select_o,
  output wire        float_mode_o,
  output wire [4:0]  trap_enable_o,
  output wire [31:0] status_o,
  // register file
  input  wire        rf_we_i,
  input  wire [4:0]  rf_waddr_i,
  input  wire [3:0]  rf_hw_en_i,
  input  wire [63:0] rf_wdata_i,
  input  wire [4:0]  rf_raddr_a_i,
  input  wire [4:0]  rf_raddr_b_i,
  output wire [63:0] rf_rdata_a_o,
  output wire [63:0] rf_rdata_b_o
);

  //////////////////////////////////////////////////////////////////////////
  // instruction fields, big-endian bit n sits at insn_i[31-n]
  wire [5:0]  f_primary = insn_i[31:26];
  wire [4:0]  f_rd      = insn_i[25:21];
  wire [1:0]  f_cmp_pad = insn_i[22:21];
  wire [4:0]  f_ra      = insn_i[20:16];
  wire [4:0]  f_rb      = insn_i[15:11];
  wire [7:0]  f_class   = insn_i[10:3];
  wire [3:0]  f_mid     = insn_i[10:7];
  wire [6:0]  f_op      = insn_i[6:0];
  wire [10:0] f_sec     = insn_i[10:0];

  wire is_p4  = (f_primary == `SFD_PRIMARY_SIMD);
  wire is_vec = is_p4 && ((f_class[7:2] == `SFD_VEC_A) ||
                          (f_class[7:1] == `SFD_VEC_B));
  wire is_scl = is_p4 && ((f_class == `SFD_SCL_A) ||
                          (f_class[7:2] == `SFD_SCL_B));
  wire is_dbl = is_p4 && ((f_class == `SFD_DBL_A) ||
                          (f_class[7:2] == `SFD_DBL_B));
  wire is_brinc = is_p4 && (f_sec == `SFD_BITREV_INC);

  //////////////////////////////////////////////////////////////////////////
  // op tables; op 0x30-0x37 or 0x40-0x5F is scalar space, 0x00-0x2F vector space
  function op_assigned;
    input [6:0] op;
    begin
      op_assigned = 1'b1;
      case (op)
        7'h0F, 7'h19, 7'h1B, 7'h1F, 7'h2D: op_assigned = 1'b0;
        7'h59, 7'h5B, 7'h5F:               op_assigned = 1'b0;
        7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37: op_assigned = 1'b0;
        7'h2E, 7'h2F: op_assigned = 1'b1;
        default: op_assigned = 1'b1;
      endcase
    end
  endfunction

  function op_is_cmp;
    input [6:0] op;
    begin
      op_is_cmp = (op[3:2] == 2'b11) && (op[1:0] != 2'b11) &&
                  ((op[6:5] == 2'b00) || (op[6:5] == 2'b10));
    end
  endfunction

  // conversions that share a code between integer and half precision
  function op_is_shared_conv;
    input [6:0] op;
    begin
      op_is_shared_conv = (op[4:0] == 5'h11) || (op[4:0] == 5'h15);
      op_is_shared_conv = op_is_shared_conv &&
                          ((op[6:5] == 2'b00) || (op[6:5] == 2'b10));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // combinational decode
  reg nxt_illegal;
  reg nxt_unimpl;
  reg nxt_unavail;
  reg nxt_half;
  reg nxt_cmp;

  always @* begin
    nxt_illegal = 1'b0;
    nxt_unimpl  = 1'b0;
    nxt_unavail = 1'b0;
    nxt_half    = 1'b0;
    nxt_cmp     = 1'b0;
    if (is_p4 && !extension_available_bit_i && !is_brinc) begin
      nxt_unavail = 1'b1;
    end else if (is_dbl) begin
      nxt_unimpl = 1'b1;
    end else if ((is_vec || is_scl) && (f_mid == `SFD_SEC_MID)) begin
      if (is_scl && (f_op == `SFD_OP_SCFD)) begin
        nxt_unimpl = 1'b1;
      end else if (!op_assigned(f_op)) begin
        nxt_illegal = 1'b1;
      end else if (op_is_cmp(f_op)) begin
        nxt_cmp     = 1'b1;
        nxt_illegal = (f_cmp_pad != 2'b00);
      end else if (op_is_shared_conv(f_op)) begin
        if (f_ra == `SFD_CONV_HALF) begin
          nxt_half = 1'b1;
        end else if (f_ra != `SFD_CONV_INT) begin
          nxt_illegal = 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered decode outputs, one cycle after the instruction
  reg       dec_valid_ff;
  reg       dec_vec_ff;
  reg       dec_scl_ff;
  reg       dec_half_ff;
  reg       dec_cmp_ff;
  reg       dec_illegal_ff;
  reg       dec_unimpl_ff;
  reg       dec_unavail_ff;
  reg [6:0] dec_op_ff;
  reg [4:0] dec_rd_ff;
  reg [4:0] dec_ra_ff;
  reg [4:0] dec_rb_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_ff   <= 1'b0;
      dec_vec_ff     <= 1'b0;
      dec_scl_ff     <= 1'b0;
      dec_half_ff    <= 1'b0;
      dec_cmp_ff     <= 1'b0;
      dec_illegal_ff <= 1'b0;
      dec_unimpl_ff  <= 1'b0;
      dec_unavail_ff <= 1'b0;
      dec_op_ff      <= 7'h00;
      dec_rd_ff      <= 5'h00;
      dec_ra_ff      <= 5'h00;
      dec_rb_ff      <= 5'h00;
    end else begin
      dec_valid_ff   <= insn_valid_i && (is_vec || is_scl || is_dbl);
      dec_vec_ff     <= insn_valid_i && is_vec;
      dec_scl_ff     <= insn_valid_i && is_scl;
      dec_half_ff    <= insn_valid_i && nxt_half;
      dec_cmp_ff     <= insn_valid_i && nxt_cmp && !nxt_illegal;
      dec_illegal_ff <= insn_valid_i && nxt_illegal;
      dec_unimpl_ff  <= insn_valid_i && nxt_unimpl;
      dec_unavail_ff <= insn_valid_i && nxt_unavail;
      if (insn_valid_i) begin
        dec_op_ff <= f_op;
        dec_rd_ff <= f_rd;
        dec_ra_ff <= f_ra;
        dec_rb_ff <= f_rb;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // condition field: only compares write it, no record forms exist
  reg       cr_we_ff;
  reg [2:0] cr_field_ff;
  reg [3:0] cr_data_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cr_we_ff    <= 1'b0;
      cr_field_ff <= 3'h0;
      cr_data_ff  <= 4'h0;
    end else begin
      cr_we_ff <= cmp_done_i;
      if (cmp_done_i) begin
        cr_field_ff <= cmp_field_i;
        cr_data_ff  <= {cmp_hi_i, cmp_lo_i, cmp_hi_i | cmp_lo_i,
                        cmp_hi_i & cmp_lo_i};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared status and control register; hardware sets land after a
  // software write in the same cycle so an event is never lost
  reg  [31:0] status_ff;
  reg  [31:0] nxt_status;
  reg  [31:0] rdata_ff;
  reg         hit_ff;
  wire        spr_sel = (spr_num_i == `SFD_SPR_STATUS);

  always @* begin
    nxt_status = status_ff;
    if (spr_wr_i && spr_sel) begin
      nxt_status = spr_wdata_i;
    end
    if (int_upd_i) begin
      nxt_status[`SFD_B_OVH]  = high_int_wrap_i;
      nxt_status[`SFD_B_HIGH_SUMMARY_INT_OVERFLOW] = nxt_status[`SFD_B_HIGH_SUMMARY_INT_OVERFLOW] | high_int_wrap_i;
      nxt_status[`SFD_B_OV]   = low_int_wrap_i;
      nxt_status[`SFD_B_SOV]  = nxt_status[`SFD_B_SOV] | low_int_wrap_i;
    end
    if (flt_upd_i) begin
      nxt_status[`SFD_F_HI_HI:`SFD_F_HI_LO] = flt_hi_i;
      nxt_status[`SFD_F_LO_HI:`SFD_F_LO_LO] = flt_lo_i;
      nxt_status[`SFD_F_STK_HI:`SFD_F_STK_LO] =
        nxt_status[`SFD_F_STK_HI:`SFD_F_STK_LO] |
        flt_hi_i[4:0] | flt_lo_i[4:0];
    end
    nxt_status = nxt_status & ~`SFD_STATUS_RSVD;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= `SFD_STATUS_RESET;
      rdata_ff  <= 32'h0000_0000;
      hit_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      hit_ff    <= (spr_rd_i || spr_wr_i) && spr_sel;
      if (spr_rd_i && spr_sel) begin
        rdata_ff <= status_ff;
      end else if (spr_rd_i) begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control fields, straight from the status flops
  assign float_mode_o      = status_ff[`SFD_B_MODE];
  assign trap_enable_o     = status_ff[`SFD_F_TEN_HI:`SFD_F_TEN_LO];
  assign rounding_select_o = status_ff[`SFD_F_RND_HI:`SFD_F_RND_LO];
  assign status_o          = status_ff;
  assign spr_rdata_o       = rdata_ff;
  assign spr_hit_o         = hit_ff;

  assign dec_valid_o   = dec_valid_ff;
  assign dec_vec_o     = dec_vec_ff;
  assign dec_scl_o     = dec_scl_ff;
  assign dec_half_o    = dec_half_ff;
  assign dec_cmp_o     = dec_cmp_ff;
  assign dec_illegal_o = dec_illegal_ff;
  assign dec_unimpl_o  = dec_unimpl_ff;
  assign dec_unavail_o = dec_unavail_ff;
  assign dec_op_o      = dec_op_ff;
  assign dec_rd_o      = dec_rd_ff;
  assign dec_ra_o      = dec_ra_ff;
  assign dec_rb_o      = dec_rb_ff;

  assign cr_we_o                = cr_we_ff;
  assign compare_target_field_o = cr_field_ff;
  assign cr_data_o              = cr_data_ff;

  //////////////////////////////////////////////////////////////////////////
  // register file; [63:32] is field 0 (high), [31:0] field 1 (low)
  sfd_regfile u_rf (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (rf_we_i),
    .waddr_i   (rf_waddr_i),
    .hw_en_i   (rf_hw_en_i),
    .wdata_i   (rf_wdata_i),
    .raddr_a_i (rf_raddr_a_i),
    .raddr_b_i (rf_raddr_b_i),
    .rdata_a_o (rf_rdata_a_o),
    .rdata_b_o (rf_rdata_b_o)
  );

endmodule // sfd_decode_status

/* File: src/sfd_map.vh */
// sfd_map.vh: offsets, field positions, opcode patterns and reset values
// assumes instructions arrive as [31:0] with big-endian bit 0 at [31]
`ifndef SFD_MAP_VH
`define SFD_MAP_VH

// primary opcode and secondary class field (bits 21-28)
`define SFD_PRIMARY_SIMD   6'h04
`define SFD_SEC_MID        4'h5
`define SFD_VEC_A          6'h14
`define SFD_VEC_B          7'h2A
`define SFD_SCL_A          8'h56
`define SFD_SCL_B          6'h16
`define SFD_DBL_A          8'h57
`define SFD_DBL_B          6'h17

// bit-reversed increment, full 11-bit secondary field
`define SFD_BITREV_INC     11'h20F

// conversion selector in the source-a field
`define SFD_CONV_INT       5'h00
`define SFD_CONV_HALF      5'h04

// selected secondary opcodes (bits 25-31)
`define SFD_OP_VADD        7'h00
`define SFD_OP_VSUB        7'h01
`define SFD_OP_VMUL        7'h08
`define SFD_OP_VDIV        7'h09
`define SFD_OP_VMAX        7'h20
`define SFD_OP_VMIN        7'h21
`define SFD_OP_SADD        7'h40
`define SFD_OP_SSUB        7'h41
`define SFD_OP_SMUL        7'h48
`define SFD_OP_SDIV        7'h49
`define SFD_OP_SSQRT       7'h47
`define SFD_OP_SMAX        7'h30
`define SFD_OP_SMIN        7'h31
`define SFD_OP_SCFD        7'h4F

// special register number and status/control register layout
`define SFD_SPR_STATUS     10'h200
`define SFD_STATUS_RESET   32'h0000_0000
`define SFD_STATUS_RSVD    32'h00C0_0080
`define SFD_B_HIGH_SUMMARY_INT_OVERFLOW         31
`define SFD_B_OVH          30
`define SFD_F_HI_HI        29
`define SFD_F_HI_LO        24
`define SFD_F_STK_HI       21
`define SFD_F_STK_LO       17
`define SFD_B_MODE         16
`define SFD_B_SOV          15
`define SFD_B_OV           14
`define SFD_F_LO_HI        13
`define SFD_F_LO_LO        8
`define SFD_F_TEN_HI       6
`define SFD_F_TEN_LO       2
`define SFD_F_RND_HI       1
`define SFD_F_RND_LO       0

// register file shape
`define SFD_RF_DEPTH       32
`define SFD_RF_AW          5
`define SFD_HW_BASE        4'h3
`define SFD_HW_FULL        4'hF

`endif

/* File: src/sfd_regfile.v */
// sfd_regfile.v: thirty-two 64-bit registers, halfword write enables
// assumes the issue logic gives halfword enables; reads are registered
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_regfile (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // write port
  input  wire        we_i,
  input  wire [4:0]  waddr_i,
  input  wire [3:0]  hw_en_i,
  input  wire [63:0] wdata_i,
  // read ports
  input  wire [4:0]  raddr_a_i,
  input  wire [4:0]  raddr_b_i,
  output wire [63:0] rdata_a_o,
  output wire [63:0] rdata_b_o
);

  //////////////////////////////////////////////////////////////////////////
  // one array per halfword so each array has a single writing process
  // halfword 3 is bits 63:48 = field 0 upper; base forms touch only 1:0
  // no bypass: a read in the write cycle returns the old value
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_hw
      reg [15:0] mem [0:`SFD_RF_DEPTH-1];
      reg [15:0] rd_a_ff;
      reg [15:0] rd_b_ff;

      always @(posedge clk_i) begin
        if (we_i && hw_en_i[g]) begin
          mem[waddr_i] <= wdata_i[g*16 +: 16];
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          rd_a_ff <= 16'h0000;
          rd_b_ff <= 16'h0000;
        end else begin
          rd_a_ff <= mem[raddr_a_i];
          rd_b_ff <= mem[raddr_b_i];
        end
      end

      assign rdata_a_o[g*16 +: 16] = rd_a_ff;
      assign rdata_b_o[g*16 +: 16] = rd_b_ff;
    end
  endgenerate

endmodule // sfd_regfile

/* File: testbench/sfd_decode_status_sva.sv */
// sfd_decode_status_sva.sv: port-level checks on the decode/status block
// assumes the map header is on the include path; bound to every instance
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_decode_status_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // decode
  input wire logic        insn_valid_i,
  input wire logic [31:0] insn_i,
  input wire logic        extension_available_bit_i,
  input wire logic        dec_vec_o,
  input wire logic        dec_scl_o,
  input wire logic        dec_unimpl_o,
  input wire logic        dec_unavail_o,
  // compare
  input wire logic        cmp_done_i,
  input wire logic [2:0]  cmp_field_i,
  input wire logic        cmp_hi_i,
  input wire logic        cmp_lo_i,
  input wire logic        cr_we_o,
  input wire logic [2:0]  compare_target_field_o,
  input wire logic [3:0]  cr_data_o,
  // status register
  input wire logic        spr_wr_i,
  input wire logic [9:0]  spr_num_i,
  input wire logic [31:0] spr_wdata_i,
  input wire logic        int_upd_i,
  input wire logic        high_int_wrap_i,
  input wire logic        flt_upd_i,
  input wire logic [1:0]  rounding_select_o,
  input wire logic        float_mode_o,
  input wire logic [4:0]  trap_enable_o,
  input wire logic [31:0] status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire       pri4 = insn_valid_i && insn_i[31:26] == `SFD_PRIMARY_SIMD;
  wire [7:0] cls  = insn_i[10:3];
  wire       hit  = spr_num_i == `SFD_SPR_STATUS;

  // events override a same-cycle write, so only a lone write is compared
  sequence lone_wr_s;
    spr_wr_i && hit && !int_upd_i && !flt_upd_i;
  endsequence
  sequence cr_out_s;
    cr_we_o && compare_target_field_o == $past(cmp_field_i);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  spr_write_a: assert property (
    lone_wr_s |=> status_o == ($past(spr_wdata_i) & ~`SFD_STATUS_RSVD))
    else $error("status write not taken");
  rsvd_zero_a: assert property (
    (status_o & `SFD_STATUS_RSVD) == 32'h0000_0000)
    else $error("reserved status bit set");
  ctrl_map_a: assert property (
    lone_wr_s |=> rounding_select_o == $past(spr_wdata_i[1:0])
    && trap_enable_o == $past(spr_wdata_i[6:2])
    && float_mode_o == $past(spr_wdata_i[16])) else $error("control outputs differ");
  hi_wrap_a: assert property (
    int_upd_i && high_int_wrap_i |=> status_o[31] && status_o[30])
    else $error("high wrap not recorded");
  sum_hold_a: assert property (
    status_o[31] && !(spr_wr_i && hit) |=> $stable(status_o[31]))
    else $error("high summary lost");
  cr_field_a: assert property (
    cmp_done_i |=> cr_out_s ##0 cr_data_o == {$past(cmp_hi_i), $past(cmp_lo_i),
      $past(cmp_hi_i) | $past(cmp_lo_i), $past(cmp_hi_i) & $past(cmp_lo_i)})
    else $error("compare field wrong");
  unavail_a: assert property (
    pri4 && !extension_available_bit_i && insn_i[10:0] != `SFD_BITREV_INC
    |=> dec_unavail_o) else $error("unavailable not raised");
  vec_cls_a: assert property (
    pri4 && extension_available_bit_i && (cls[7:2] == `SFD_VEC_A
    || cls[7:1] == `SFD_VEC_B) |=> dec_vec_o && !dec_scl_o)
    else $error("vector class missed");
  scl_cls_a: assert property (
    pri4 && extension_available_bit_i && (cls == `SFD_SCL_A
    || cls[7:2] == `SFD_SCL_B) |=> dec_scl_o && !dec_vec_o)
    else $error("scalar class missed");
  dbl_cls_a: assert property (
    pri4 && extension_available_bit_i && (cls == `SFD_DBL_A
    || cls[7:2] == `SFD_DBL_B) |=> dec_unimpl_o && !dec_scl_o)
    else $error("double space not refused");
endmodule // sfd_decode_status_chk

bind sfd_decode_status sfd_decode_status_chk u_chk (.*);

/* File: testbench/sfd_decode_status_tb_top.sv */
// sfd_decode_status_tb_top.sv: self-checking bench for the decode/status block
// assumes design and checker compiled first; inputs move on falling edges
`timescale 1ns/1ps

module sfd_decode_status_tb_top;
  logic clk_i, rst_i, extension_available_bit_i, cmp_done_i, cmp_hi_i, cmp_lo_i;
  logic spr_wr_i, spr_rd_i, int_upd_i, high_int_wrap_i, low_int_wrap_i, flt_upd_i, rf_we_i;
  logic [2:0] cmp_field_i;
  logic [9:0] spr_num_i;
  logic [31:0] spr_wdata_i;
  logic [5:0] flt_hi_i, flt_lo_i;
  logic [4:0] rf_waddr_i, rf_raddr_a_i, rf_raddr_b_i;
  logic [3:0] rf_hw_en_i;
  logic [63:0] rf_wdata_i;
  wire logic insn_valid_i, dec_valid_o, dec_vec_o, dec_scl_o, dec_half_o, dec_cmp_o;
  wire logic dec_illegal_o, dec_unimpl_o, dec_unavail_o, cr_we_o, spr_hit_o, float_mode_o;
  wire logic [31:0] insn_i, spr_rdata_o, status_o;
  wire logic [6:0] dec_op_o;
  wire logic [4:0] dec_rd_o, dec_ra_o, dec_rb_o, trap_enable_o;
  wire logic [2:0] compare_target_field_o;
  wire logic [3:0] cr_data_o;
  wire logic [1:0] rounding_select_o;
  wire logic [63:0] rf_rdata_a_o, rf_rdata_b_o;
  int n_mismatch, samples_checked, cyc;

  sfd_decode_status DUT (.*);
  sfd_issue_model u_iss (.clk_i(clk_i), .insn_valid_o(insn_valid_i), .insn_o(insn_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] mk(input logic [4:0] rd, ra, rb, input logic [6:0] op);
    return {6'h04, rd, ra, rb, 4'h5, op};
  endfunction
  task automatic spr(input logic wr, rd, input logic [9:0] num, input logic [31:0] d);
    @(negedge clk_i);
    {spr_wr_i, spr_rd_i, spr_num_i, spr_wdata_i} = {wr, rd, num, d};
    @(negedge clk_i);
    {spr_wr_i, spr_rd_i} = 2'b00;
  endtask
  task automatic ev(input logic iu, hw, lw, fu, input logic [5:0] hi, lo);
    @(negedge clk_i);
    {int_upd_i, high_int_wrap_i, low_int_wrap_i, flt_upd_i, flt_hi_i, flt_lo_i} =
      {iu, hw, lw, fu, hi, lo};
    @(negedge clk_i);
    {int_upd_i, flt_upd_i} = 2'b00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_class;
    logic [6:0] ops [8];
    logic [2:0] ex [8];
    ops = '{7'h00, 7'h09, 7'h21, 7'h30, 7'h40, 7'h47, 7'h38, 7'h60};
    ex = '{3'b100, 3'b100, 3'b100, 3'b010, 3'b010, 3'b010, 3'b001, 3'b001};
    for (int i = 0; i < 8; i++) begin
      u_iss.issue(mk(5'h03, 5'h0A, 5'h11, ops[i]));
      chk("class", {1'b1, ex[i]}, {dec_valid_o, dec_vec_o, dec_scl_o, dec_unimpl_o});
      chk("fields", {ops[i], 15'h0D51}, {dec_op_o, dec_rd_o, dec_ra_o, dec_rb_o});
    end
    $display("t_class done");
  endtask
  task automatic t_ext;
    extension_available_bit_i = 1'b0;
    u_iss.issue(mk(5'h01, 5'h02, 5'h03, 7'h00));
    chk("unavail vec", 2'b10, {dec_unavail_o, dec_unimpl_o});
    u_iss.issue({6'h04, 15'h0443, 11'h20F});
    chk("unavail brinc", 1'b0, dec_unavail_o);
    u_iss.issue(mk(5'h01, 5'h02, 5'h03, 7'h38));
    chk("unavail dbl", 2'b10, {dec_unavail_o, dec_unimpl_o});
    extension_available_bit_i = 1'b1;
    u_iss.issue(mk(5'h01, 5'h02, 5'h03, 7'h60));
    chk("unimpl dbl", 2'b01, {dec_unavail_o, dec_unimpl_o});
    $display("t_ext done");
  endtask
  task automatic t_conv;
    logic [19:0] tb [9];
    tb = '{{5'h01, 5'h04, 7'h11, 3'b100}, {5'h01, 5'h00, 7'h11, 3'b000},
           {5'h01, 5'h02, 7'h11, 3'b010}, {5'h01, 5'h04, 7'h55, 3'b100},
           {5'h01, 5'h00, 7'h0F, 3'b010}, {5'h08, 5'h02, 7'h0C, 3'b001},
           {5'h09, 5'h02, 7'h0C, 3'b010}, {5'h0C, 5'h02, 7'h5E, 3'b001},
           {5'h0B, 5'h02, 7'h1C, 3'b010}};
    for (int i = 0; i < 9; i++) begin
      u_iss.issue(mk(tb[i][19:15], tb[i][14:10], 5'h05, tb[i][9:3]));
      chk("conv", tb[i][2:0], {dec_half_o, dec_illegal_o, dec_cmp_o});
    end
    $display("t_conv done");
  endtask
  task automatic t_cmp;
    logic h, l;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_i);
      if (i > 0) begin
        {h, l} = 2'(i - 1);
        chk("cr", {1'b1, 3'(i + 1), h, l, h | l, h & l},
            {cr_we_o, compare_target_field_o, cr_data_o});
      end
      {cmp_field_i, cmp_hi_i, cmp_lo_i} = {3'(i + 2), 2'(i)};
      cmp_done_i = (i < 4);
    end
    $display("t_cmp done");
  endtask
  task automatic t_spr;
    spr(1'b1, 1'b0, 10'h200, 32'hFFFF_FFFF);
    chk("status", 32'hFF3F_FF7F, status_o);
    chk("ctrl", 9'h1FF, {spr_hit_o, rounding_select_o, trap_enable_o, float_mode_o});
    spr(1'b0, 1'b1, 10'h200, 32'h0000_0000);
    chk("read", 32'hFF3F_FF7F, spr_rdata_o);
    spr(1'b1, 1'b1, 10'h1F0, 32'h0000_0000);
    chk("miss", {1'b0, 64'hFF3F_FF7F}, {spr_hit_o, spr_rdata_o, status_o});
    spr(1'b1, 1'b0, 10'h200, 32'h0000_0000);
    chk("clear", 32'h0000_0000, status_o);
    $display("t_spr done");
  endtask
  task automatic t_events;
    ev(1'b1, 1'b1, 1'b0, 1'b0, 6'h00, 6'h00);
    chk("high wrap", 32'hC000_0000, status_o);
    ev(1'b1, 1'b0, 1'b1, 1'b0, 6'h00, 6'h00);
    chk("low wrap", 32'h8000_C000, status_o);
    ev(1'b0, 1'b0, 1'b0, 1'b1, 6'h21, 6'h12);
    chk("float", 32'hA126_D200, status_o);
    ev(1'b0, 1'b0, 1'b0, 1'b1, 6'h00, 6'h00);
    chk("sticky", 32'h8026_C000, status_o);
    fork
      spr(1'b1, 1'b0, 10'h200, 32'h0000_0000);
      ev(1'b1, 1'b1, 1'b0, 1'b0, 6'h00, 6'h00);
    join
    chk("set wins", 32'hC000_0000, status_o);
    spr(1'b1, 1'b0, 10'h200, 32'h0000_0000);
    chk("wipe", 32'h0000_0000, status_o);
    $display("t_events done");
  endtask
  task automatic t_rf;
    @(negedge clk_i);
    {rf_we_i, rf_waddr_i, rf_hw_en_i} = {1'b1, 5'h03, 4'hF};
    rf_wdata_i = 64'h1111_2222_3333_4444;
    @(negedge clk_i);
    {rf_hw_en_i, rf_wdata_i} = {4'h3, 64'hAAAA_BBBB_CCCC_DDDD};
    @(negedge clk_i);
    {rf_we_i, rf_raddr_a_i, rf_raddr_b_i} = {1'b0, 5'h03, 5'h03};
    @(negedge clk_i);
    chk("rf", {2{64'h1111_2222_CCCC_DDDD}}, {rf_rdata_a_o, rf_rdata_b_o});
    $display("t_rf done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 75 cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    {rst_i, extension_available_bit_i} = 2'b11;
    {cmp_done_i, cmp_hi_i, cmp_lo_i, cmp_field_i} = 6'h00;
    {spr_wr_i, spr_rd_i, spr_num_i, spr_wdata_i} = 44'h0;
    {int_upd_i, high_int_wrap_i, low_int_wrap_i, flt_upd_i, flt_hi_i, flt_lo_i} = 16'h0;
    {rf_we_i, rf_waddr_i, rf_hw_en_i, rf_wdata_i, rf_raddr_a_i, rf_raddr_b_i} = 84'h0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk("reset", 35'h0, {status_o, spr_hit_o, cr_we_o, dec_valid_o});
    t_class();
    t_ext();
    t_conv();
    t_cmp();
    t_spr();
    t_events();
    t_rf();
    end_of_test();
  end
endmodule // sfd_decode_status_tb_top

/* File: testbench/sfd_issue_model.sv */
// sfd_issue_model.sv: issue pipeline stand-in, one word per call
// assumes the bench calls issue() and samples decode flags on return
`timescale 1ns/1ps

module sfd_issue_model (
  // clock
  input  wire logic        clk_i,
  // issue stream
  output logic             insn_valid_o,
  output logic [31:0]      insn_o
);
  initial begin
    insn_valid_o = 1'b0;
    insn_o = 32'h0000_0000;
  end
  // idle word is inverted so stale opcodes never look valid by accident
  task automatic issue(input logic [31:0] w);
    @(negedge clk_i);
    insn_valid_o = 1'b1;
    insn_o = w;
    @(negedge clk_i);
    insn_valid_o = 1'b0;
    insn_o = ~w;
  endtask
endmodule // sfd_issue_model
